//--- logic/hb_driver_ctrl.sv
// serial control of the twelve-switch half-bridge driver
// assumes host-driven serial clock, select and data, sampled by clk_i
`timescale 1ns/100ps
module hb_driver_ctrl #(
  parameter int unsigned OC_CYC = hb_driver_pkg::OC_DEAD_CYC,
  parameter int unsigned UL_CYC = hb_driver_pkg::UL_DEAD_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        select_low_i,
  input  wire logic        serial_clk_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_n_o,
  input  wire logic        standby_inhibit_n_i,
  input  wire logic        logic_undervolt_i,
  input  wire logic        supply_undervolt_i,
  input  wire logic        supply_overvolt_i,
  input  wire logic        temp_warn_i,
  input  wire logic        temp_shutdown_i,
  input  wire logic [11:0] overcurrent_i,
  input  wire logic [11:0] underload_i,
  output logic [11:0]      output_on_o,
  output logic [11:0]      output_hiz_o,
  output logic [11:0]      current_limit_o
);
  localparam int unsigned NS = 9;
  // idle levels: select and inhibit high, all else low
  localparam logic [NS-1:0] PIN_IDLE = 9'h102;
  // synchronisers
  logic [NS-1:0]  s1_reg, s2_reg, s3_reg;
  logic [23:0]    a1_reg, a2_reg;
  logic [NS-1:0]  pins;
  assign pins = {select_low_i, serial_clk_i, serial_in_i, temp_warn_i, supply_undervolt_i,
                 supply_overvolt_i, logic_undervolt_i, standby_inhibit_n_i, temp_shutdown_i};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_reg <= PIN_IDLE;
      s2_reg <= PIN_IDLE;
      s3_reg <= PIN_IDLE;
      a1_reg <= 24'h00_0000;
      a2_reg <= 24'h00_0000;
    end else if (ce_i) begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      a1_reg <= {overcurrent_i, underload_i};
      a2_reg <= a1_reg;
    end
  end
  logic sel_n, sck, sdi, sel_fall, sel_rise, sck_rise, sck_fall;
  logic vs_fault, uv_s, ov_s, vuv_s, tw_s, inh_n_s, tsd_s;
  logic [11:0] oc_s, ul_s;
  assign sel_n    = s2_reg[8];
  assign sck      = s2_reg[7];
  assign sdi      = s2_reg[6];
  assign tw_s     = s2_reg[5];
  assign vuv_s    = s2_reg[4];
  assign ov_s     = s2_reg[3];
  assign uv_s     = s2_reg[2];
  assign inh_n_s  = s2_reg[1];
  assign tsd_s    = s2_reg[0];
  assign sel_fall = s3_reg[8] && !sel_n;
  assign sel_rise = !s3_reg[8] && sel_n;
  assign sck_rise = !s3_reg[7] && sck;
  assign sck_fall = s3_reg[7] && !sck;
  assign {oc_s, ul_s} = a2_reg;
  assign vs_fault = vuv_s || ov_s;

  // inhibit or logic undervoltage erases control word, flags and any open frame
  logic wipe;
  assign wipe = !inh_n_s || uv_s;

  // serial shift path
  hb_driver_pkg::ctl_word_t ctl_reg, ctl_next;
  logic [15:0] rx_reg, rx_next, tx_reg, tx_next, sts_word;
  logic [4:0]  cnt_reg, cnt_next;
  logic        act_reg, act_next, oe_reg, oe_next;
  logic [23:0] ul_reg, ul_next;
  hb_driver_pkg::fault_flags_t flg_reg, flg_next;
  logic [11:0] drive, trip;

  // status word: bits 1..12 follow control order
  assign sts_word = {flg_reg.supply_fault, flg_reg.underload, flg_reg.overload,
                     drive, flg_reg.temp_warn};

  always_comb begin
    rx_next  = rx_reg;
    tx_next  = tx_reg;
    cnt_next = cnt_reg;
    act_next = act_reg;
    oe_next  = oe_reg;
    ctl_next = ctl_reg;
    ul_next  = (ul_reg != 24'h00_0000) ? ul_reg - 24'h00_0001 : ul_reg;
    flg_next = flg_reg;
    if (sel_fall) begin
      act_next = 1'b1;
      cnt_next = 5'h00;
      tx_next  = sts_word;
      oe_next  = 1'b1;
    end else if (act_reg && sck_rise && cnt_reg < 5'(hb_driver_pkg::WORD_BITS)) begin
      rx_next  = {rx_reg[14:0], sdi};
      cnt_next = cnt_reg + 5'h01;
    end else if (act_reg && sck_fall && cnt_reg != 5'h00) begin
      tx_next = {tx_reg[14:0], 1'b0};
    end
    if (sel_rise && act_reg) begin
      act_next = 1'b0;
      oe_next  = 1'b0;
      if (cnt_reg == 5'(hb_driver_pkg::WORD_BITS)) begin
        ctl_next = rx_reg;
        ul_next  = 24'(UL_CYC);
        if (rx_reg[hb_driver_pkg::CTL_STATUS_CLR]) begin
          flg_next = '0;
        end
      end
    end
    // events set after the clear so they win
    if (|trip) begin
      flg_next.overload = 1'b1;
    end
    if (ul_reg == 24'h00_0000 && |(ul_s & drive)) begin
      flg_next.underload = 1'b1;
    end
    if (vs_fault) begin
      flg_next.supply_fault = 1'b1;
    end
    if (tw_s) begin
      flg_next.temp_warn = 1'b1;
    end
    if (wipe) begin
      ctl_next = hb_driver_pkg::CTL_RESET;
      flg_next = '0;
      act_next = 1'b0;
      oe_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_reg  <= 16'h0000;
      tx_reg  <= 16'h0000;
      cnt_reg <= 5'h00;
      act_reg <= 1'b0;
      oe_reg  <= 1'b0;
      ctl_reg <= hb_driver_pkg::CTL_RESET;
      ul_reg  <= 24'h00_0000;
      flg_reg <= '0;
    end else if (ce_i) begin
      rx_reg  <= rx_next;
      tx_reg  <= tx_next;
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      oe_reg  <= oe_next;
      ctl_reg <= ctl_next;
      ul_reg  <= ul_next;
      flg_reg <= flg_next;
    end
  end

  assign serial_out_o      = tx_reg[15];
  assign serial_out_oe_n_o = !oe_reg;

  // supply undervoltage always cuts, overvoltage only when locked out
  logic kill;
  assign kill = wipe || tsd_s || vuv_s || (ov_s && ctl_reg.ov_lock_en);

  // channels: even index low side, odd high side of block i/2
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_ch
      logic lim;
      hb_channel #(
        .OC_CYC (OC_CYC),
        .ON_DLY ((g % 2 == 0) ? hb_driver_pkg::LS_DELAY_CYC : 1)
      ) u_ch (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .cmd_on_i   (ctl_reg.sw_on[g] && !kill),
        .block_i    (drive[g ^ 1] || ctl_reg.sw_on[g ^ 1] && (g % 2 == 0)),
        .oc_sd_en_i (ctl_reg.oc_sd_en),
        .oc_i       (oc_s[g]),
        .drive_o    (drive[g]),
        .limit_o    (lim),
        .trip_o     (trip[g])
      );
      assign current_limit_o[g] = lim;
      assign output_on_o[g]     = drive[g];
      assign output_hiz_o[g]    = !drive[g];
    end
  endgenerate

  property p_no_cross;
    @(posedge clk_i) disable iff (!rst_n_i)
      (drive & (drive >> 1) & 12'h555) == 12'h000;
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("both switches of a block on");
  property p_oe_drop;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && sel_rise && act_reg) |=> serial_out_oe_n_o;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("serial out not released");
  property p_apply;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && sel_rise && act_reg && cnt_reg == 5'd16 && !wipe) |=> ctl_reg == $past(rx_reg);
  endproperty
  a_apply: assert property (p_apply) else $error("word not applied");
  property p_wipe;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && wipe) |=> (ctl_reg == 16'h0000);
  endproperty
  a_wipe: assert property (p_wipe) else $error("inhibit kept data");
  property p_ul_mask;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && ul_reg > 24'd1 && !flg_reg.underload) |=> !flg_reg.underload;
  endproperty
  a_ul_mask: assert property (p_ul_mask) else $error("underload stored in dead time");
  property p_trip;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && |trip && !wipe) |=> flg_reg.overload;
  endproperty
  a_trip: assert property (p_trip) else $error("overload not recorded");
  sequence s_wipe_held;
    (ce_i && wipe) ##1 (ce_i && wipe);
  endsequence
  property p_kill;
    @(posedge clk_i) disable iff (!rst_n_i)
      s_wipe_held |=> (output_on_o == 12'h000);
  endproperty
  a_kill: assert property (p_kill) else $error("output on under wipe");
  property p_uv_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      (ce_i && vuv_s) ##1 (ce_i && vuv_s) |=> (output_on_o == 12'h000);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("output on in undervoltage");
  property p_cnt;
    @(posedge clk_i) disable iff (!rst_n_i) cnt_reg <= 5'd16;
  endproperty
  a_cnt: assert property (p_cnt) else $error("more than sixteen bits taken");
endmodule

//--- logic/hb_driver_pkg.sv
// constants and carrier types for the serial half-bridge driver control
// assumes a 250 MHz system clock and a host that frames 16-bit words
package hb_driver_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned WORD_BITS       = 16;
  localparam int unsigned NUM_BLOCKS      = 6;
  localparam int unsigned NUM_SWITCHES    = 12;
  // control word fields
  localparam int unsigned CTL_STATUS_CLR  = 0;
  localparam int unsigned CTL_SW_LSB      = 1;
  localparam int unsigned CTL_OC_SD_EN    = 13;
  localparam int unsigned CTL_UNUSED      = 14;
  localparam int unsigned CTL_OV_LOCK_EN  = 15;
  // status word fields
  localparam int unsigned STS_TEMP_WARN   = 0;
  localparam int unsigned STS_SW_LSB      = 1;
  localparam int unsigned STS_OVERLOAD    = 13;
  localparam int unsigned STS_UNDERLOAD   = 14;
  localparam int unsigned STS_SUPPLY_FAIL = 15;
  localparam logic [15:0] CTL_RESET       = 16'h0000;
  localparam logic [15:0] STS_RESET       = 16'h0000;
  // timing, figures in ns
  localparam int unsigned OC_DEAD_NS      = 50000;
  localparam int unsigned OC_DEAD_CYC     = OC_DEAD_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned UL_DEAD_NS      = 300000;
  localparam int unsigned UL_DEAD_CYC     = UL_DEAD_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned LS_DELAY_NS     = 200;
  localparam int unsigned LS_DELAY_CYC    = (LS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;

  typedef struct packed {
    logic ov_lock_en;
    logic unused;
    logic oc_sd_en;
    logic [11:0] sw_on;
    logic status_clr;
  } ctl_word_t;

  typedef struct packed {
    logic overload;
    logic underload;
    logic supply_fault;
    logic temp_warn;
  } fault_flags_t;
endpackage

//--- logic/hb_channel.sv
// one switch channel: overcurrent dead timer, cutoff and turn-on delay
// assumes sense inputs already synchronised to clk_i
`timescale 1ns/100ps
module hb_channel #(
  parameter int unsigned OC_CYC = hb_driver_pkg::OC_DEAD_CYC,
  parameter int unsigned ON_DLY = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic cmd_on_i,
  input  wire logic block_i,
  input  wire logic oc_sd_en_i,
  input  wire logic oc_i,
  output logic      drive_o,
  output logic      limit_o,
  output logic      trip_o
);
  logic [23:0] oc_cnt_reg,  oc_cnt_next;
  logic [7:0]  dly_reg,     dly_next;
  logic        cut_reg,     cut_next;
  logic        drive_reg,   drive_next;

  always_comb begin
    oc_cnt_next = oc_cnt_reg;
    dly_next    = dly_reg;
    cut_next    = cut_reg;
    drive_next  = 1'b0;
    trip_o      = 1'b0;
    if (!cmd_on_i) begin
      cut_next    = 1'b0;
      oc_cnt_next = '0;
      dly_next    = '0;
    end else begin
      if (block_i) begin
        dly_next = '0;  // partner still on: hold off
      end else if (dly_reg < 8'(ON_DLY)) begin
        dly_next = dly_reg + 8'd1;
      end
      if (oc_i && drive_reg && oc_sd_en_i && !cut_reg) begin
        if (oc_cnt_reg >= 24'(OC_CYC - 1)) begin
          cut_next = 1'b1;
          trip_o   = 1'b1;
        end else begin
          oc_cnt_next = oc_cnt_reg + 24'd1;
        end
      end else if (!oc_i || !oc_sd_en_i) begin
        oc_cnt_next = '0;
      end
      drive_next = !block_i && (dly_reg >= 8'(ON_DLY)) && !cut_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      oc_cnt_reg <= '0;
      dly_reg    <= '0;
      cut_reg    <= 1'b0;
      drive_reg  <= 1'b0;
    end else if (ce_i) begin
      oc_cnt_reg <= oc_cnt_next;
      dly_reg    <= dly_next;
      cut_reg    <= cut_next;
      drive_reg  <= drive_next;
    end
  end

  assign drive_o = drive_reg;
  assign limit_o = drive_reg && oc_i;
endmodule

//--- testbench/hb_host_model.sv
// host-side serial master: select, link clock and data toward the driver
// assumes the device samples on link clock rise and shifts on its fall
`timescale 1ns/100ps
module hb_host_model (
  input  wire logic clk_i,
  input  wire logic serial_out_i,
  output logic      select_low_o,
  output logic      serial_clk_o,
  output logic      serial_in_o
);
  // 24 ns half period of the 48 ns link clock
  localparam int HALF = 6;
  initial begin
    select_low_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_in_o  = 1'b0;
  end
  // frame of nbits, msb first, link clock idle low outside frames
  task automatic xfer(input logic [15:0] ctl, input int nbits, output logic [15:0] sts);
    select_low_o = 1'b0;
    repeat (HALF) @(negedge clk_i);
    for (int i = 15; i > 15 - nbits; i--) begin
      serial_in_o = ctl[i];
      repeat (HALF) @(negedge clk_i);
      sts[i] = serial_out_i;
      serial_clk_o = 1'b1;
      repeat (HALF) @(negedge clk_i);
      serial_clk_o = 1'b0;
    end
    serial_in_o = ~serial_in_o;
    repeat (HALF) @(negedge clk_i);
    select_low_o = 1'b1;
    repeat (HALF) @(negedge clk_i);
  endtask
endmodule

//--- testbench/test_spi_halfbridge_driver_control.sv
// bench for the serial half-bridge driver control
// assumes the host model drives the link and short dead times
`timescale 1ns/100ps
module test_spi_halfbridge_driver_control;
  localparam int unsigned OC = 20;
  localparam int unsigned UL = 40;
  logic        clk_i     = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic        inhibit_n = 1'b1;
  logic        logic_uv  = 1'b0;
  logic        supply_uv = 1'b0;
  logic        supply_ov = 1'b0;
  logic        temp_warn = 1'b0;
  logic [11:0] oc        = 12'h000;
  logic [11:0] ul        = 12'h000;
  logic        select_low, serial_clk, serial_in, serial_out, oe_n, miso;
  logic [11:0] on, hiz, limit;
  logic [15:0] sts, want, word;
  logic [31:0] seed      = 32'h0000_005d;
  int          n_errors  = 0;
  int          num_checks = 0;
  int          cycles    = 0;
  int          ch;

  always #2 clk_i = ~clk_i;

  hb_driver_ctrl #(.OC_CYC(OC), .UL_CYC(UL)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .select_low_i(select_low),
    .serial_clk_i(serial_clk), .serial_in_i(serial_in), .serial_out_o(serial_out),
    .serial_out_oe_n_o(oe_n), .standby_inhibit_n_i(inhibit_n),
    .logic_undervolt_i(logic_uv), .supply_undervolt_i(supply_uv),
    .supply_overvolt_i(supply_ov), .temp_warn_i(temp_warn), .temp_shutdown_i(1'b0),
    .overcurrent_i(oc), .underload_i(ul), .output_on_o(on), .output_hiz_o(hiz),
    .current_limit_o(limit));

  hb_host_model host (.clk_i(clk_i), .serial_out_i(miso),
    .select_low_o(select_low), .serial_clk_o(serial_clk), .serial_in_o(serial_in));

  // released line shows the inverse of the last bit, so a late drive is seen
  assign miso = oe_n ? ~serial_out : serial_out;

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // high side wins a pair, low side only when its partner is off
  function automatic logic [11:0] drive_of(input logic [15:0] c);
    logic [11:0] d;
    d = c[12:1];
    for (int i = 0; i < 6; i++) d[2*i] = c[2*i+1] & ~c[2*i+2];
    return d;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      summarize();
    end
  end

  // both switches of a pair on together
  always @(negedge clk_i) begin
    if (rst_n_i && (on & (on >> 1) & 12'h555) != 12'h000) begin
      n_errors++;
      $display("[FAIL] pair overlap expected 000 seen %h", on);
    end
  end

  initial begin
    tick(8);
    rst_n_i = 1'b1;
    tick(4);
    host.xfer(16'h0001, 16, sts);
    check("reset status", 16'h0000, sts);
    check("output enable after select", 16'h0001, {15'h0000, oe_n});
    want = 16'h0000;
    for (int k = 0; k < 12; k++) begin
      word = rnd() | 16'h0001;
      host.xfer(word, 16, sts);
      check("previous status", want, sts);
      tick(80);
      check("drive", {4'h0, drive_of(word)}, {4'h0, on});
      check("tristate", {4'h0, ~drive_of(word)}, {4'h0, hiz});
      want = {3'b000, drive_of(word), 1'b0};
    end
    host.xfer(16'hffff, 15, sts);
    tick(80);
    check("short frame", {4'h0, drive_of(word)}, {4'h0, on});
    host.xfer(16'h0005, 16, sts);
    tick(80);
    host.xfer(16'h0003, 16, sts);
    check("low side held", 16'h0000, {4'h0, on});
    tick(80);
    check("low side on", 16'h0001, {4'h0, on});
    for (int s = 0; s < 2; s++) begin
      ch = rnd() % 12;
      word = 16'h0001 | (16'h0002 << ch) | (s == 1 ? 16'h2000 : 16'h0000);
      host.xfer(word, 16, sts);
      tick(80);
      oc[ch] = 1'b1;
      tick(6);
      check("limit", 16'h0001, {15'h0000, limit[ch]});
      check("drive while limited", 16'h0001, {15'h0000, on[ch]});
      tick(OC + 20);
      check("drive after overcurrent", {15'h0000, s == 0}, {15'h0000, on[ch]});
      oc = 12'h000;
      host.xfer(word & 16'hfffe, 16, sts);
      if (s == 1) check("overload", 16'h2000, sts);
      else check("limited drive", 16'h0001, {15'h0000, sts[ch+1]});
    end
    host.xfer(16'h0001, 16, sts);
    check("flags kept", 16'h2000, sts);
    host.xfer(16'h0000, 16, sts);
    check("flags cleared", 16'h0000, sts);
    ch = rnd() % 12;
    word = 16'h0001 | (16'h0002 << ch);
    ul[ch] = 1'b1;
    host.xfer(word, 16, sts);
    tick(14);
    ul[ch] = 1'b0;
    tick(60);
    host.xfer(word, 16, sts);
    check("underload masked", 16'h0002 << ch, sts);
    tick(60);
    ul[ch] = 1'b1;
    tick(20);
    ul[ch] = 1'b0;
    host.xfer(word, 16, sts);
    check("underload", 16'h4000 | (16'h0002 << ch), sts);
    supply_uv = 1'b1;
    temp_warn = 1'b1;
    tick(10);
    check("undervoltage", 16'h0fff, {4'h0, hiz});
    supply_uv = 1'b0;
    temp_warn = 1'b0;
    tick(10);
    host.xfer(word, 16, sts);
    check("supply and temp", 16'h0003, {14'h0000, sts[15], sts[0]});
    for (int v = 0; v < 2; v++) begin
      host.xfer(16'h0004 | (v == 1 ? 16'h8000 : 16'h0000), 16, sts);
      tick(10);
      supply_ov = 1'b1;
      tick(10);
      check("overvoltage lockout", {15'h0000, v == 0}, {15'h0000, on[1]});
      supply_ov = 1'b0;
      tick(10);
    end
    for (int w = 0; w < 2; w++) begin
      host.xfer(16'h1ffe, 16, sts);
      tick(80);
      if (w == 0) inhibit_n = 1'b0;
      else logic_uv = 1'b1;
      tick(10);
      check("wipe tristate", 16'h0fff, {4'h0, hiz});
      inhibit_n = 1'b1;
      logic_uv = 1'b0;
      tick(10);
      host.xfer(16'h0000, 16, sts);
      check("wiped status", 16'h0000, sts);
    end
    summarize();
  end
endmodule
